// ---- common/sbc_pkg.sv ----
package sbc_pkg;
	// Frame layout, most significant bit first
	localparam int FRAME_BITS = 16;
	localparam int HDR_BITS   = 4;
	localparam int DATA_BITS  = 12;
	localparam int POS_ADDR   = 14;
	localparam int POS_FSEL   = 13;
	localparam int POS_RO     = 12;
	localparam int POS_NWP    = 6;
	localparam int POS_OM     = 3;
	// Register addresses
	localparam logic [1:0] ADDR_MODE = 2'h0;
	localparam logic [1:0] ADDR_IRQ  = 2'h1;
	localparam logic [1:0] ADDR_CFG  = 2'h2;
	localparam logic [1:0] ADDR_PHY  = 2'h3;
	localparam logic [11:0] REG_RESET = 12'h000;
	// Current operating mode, as reported by the system controller
	localparam logic [2:0] MODE_STARTUP = 3'h0;
	localparam logic [2:0] MODE_RESTART = 3'h1;
	localparam logic [2:0] MODE_NORMAL  = 3'h2;
	localparam logic [2:0] MODE_STANDBY = 3'h3;
	localparam logic [2:0] MODE_FLASH   = 3'h4;
	// Requested operating mode codes
	localparam logic [2:0] OM_NORMAL      = 3'h1;
	localparam logic [2:0] OM_STANDBY     = 3'h2;
	localparam logic [2:0] OM_INIT_FLASH  = 3'h3;
	localparam logic [2:0] OM_SLEEP       = 3'h4;
	localparam logic [2:0] OM_INIT_NORMAL = 3'h5;
	localparam logic [2:0] OM_LEAVE_FLASH = 3'h6;
	localparam logic [2:0] OM_FLASH       = 3'h7;
	// Interrupt flags
	localparam int          IRQ_SPI_BIT      = 0;
	localparam logic [11:0] LIMITED_SRC_MASK = 12'h0ff0;
	// Reset source codes
	localparam logic [3:0] RSRC_NONE        = 4'h0;
	localparam logic [3:0] RSRC_IRQ_TIMEOUT = 4'h1;
	localparam logic [3:0] RSRC_SPI_CLOCK   = 4'h2;
	localparam logic [3:0] RSRC_BAD_MODE    = 4'h3;
	localparam logic [3:0] RSRC_BAD_CODE    = 4'h4;
	localparam logic [3:0] RSRC_FLASH_ENTRY = 4'h5;
	// Times and derived cycle counts
	localparam int CLK_PERIOD_NS          = 50;
	localparam int IRQ_RELEASE_TIME_NS    = 2000;
	localparam int IRQ_RELEASE_CYCLES     = (IRQ_RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IRQ_READOUT_TIMEOUT_US = 1000;
	localparam int IRQ_READOUT_CYCLES     = IRQ_READOUT_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
	localparam int RESET_PULSE_TIME_NS    = 1000;
	localparam int RESET_PULSE_CYCLES     = (RESET_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Watchdog period codes that are defined
	function automatic logic nwp_legal(input logic [5:0] c);
		case (c)
			6'h09, 6'h0c, 6'h12, 6'h14, 6'h1b, 6'h24, 6'h2d, 6'h33, 6'h35, 6'h36: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Mode changes permitted from the current mode
	function automatic logic mode_allowed(input logic [2:0] cur, input logic [2:0] om,
			input logic armed);
		case (cur)
			MODE_STARTUP, MODE_RESTART: return (om == OM_INIT_NORMAL) || (om == OM_INIT_FLASH && armed);
			MODE_NORMAL: return (om == OM_NORMAL) || (om == OM_STANDBY) || (om == OM_SLEEP)
					|| (om == OM_FLASH);
			MODE_STANDBY: return (om == OM_NORMAL) || (om == OM_STANDBY) || (om == OM_SLEEP);
			MODE_FLASH: return (om == OM_FLASH) || (om == OM_LEAVE_FLASH);
			default: return 1'b0;
		endcase
	endfunction
endpackage

// ---- common/sbc_frame_if.sv ----
interface sbc_frame_if;
	logic [3:0]  hdr;
	logic        hdr_stb;
	logic [11:0] rd_word;
	logic        done;
	logic        len_ok;
	logic [15:0] rx_word;
	modport shifter (output hdr, hdr_stb, done, len_ok, rx_word, input rd_word);
	modport core (input hdr, hdr_stb, done, len_ok, rx_word, output rd_word);
endinterface

// ---- verilog/sbc_spi_shifter.sv ----
module sbc_spi_shifter
	import sbc_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    rst_n,
	input  wire logic    sck_pin,
	input  wire logic    cs_n_pin,
	input  wire logic    sdi_pin,
	output logic         serial_out,
	output logic         sdo_oe,
	sbc_frame_if.shifter fr
);
	typedef struct packed {
		logic [2:0]  sck;
		logic [2:0]  cs;
		logic [1:0]  serial_in;
		logic        active;
		logic [4:0]  falls;
		logic [4:0]  rises;
		logic [15:0] rx;
		logic        serial_out;
		logic        sdo_oe;
		logic        hdr_stb;
		logic        done;
		logic        len_ok;
	} sbc_shift_t;

	sbc_shift_t q;
	sbc_shift_t d;
	logic       fall_e;
	logic       rise_e;
	logic       cs_fall;
	logic       cs_rise;

	// Edges seen after two synchroniser stages
	assign fall_e  = q.sck[2] & ~q.sck[1];
	assign rise_e  = ~q.sck[2] & q.sck[1];
	assign cs_fall = q.cs[2] & ~q.cs[1];
	assign cs_rise = ~q.cs[2] & q.cs[1];

	// Next state of the shift engine
	always_comb begin
		d = q;
		d.sck = {q.sck[1:0], sck_pin};
		d.cs = {q.cs[1:0], cs_n_pin};
		d.serial_in = {q.serial_in[0], sdi_pin};
		d.hdr_stb = '0;
		d.done = '0;
		if (cs_fall) begin
			d.active = '1;
			d.falls = 5'h00;
			d.rises = 5'h00;
			d.serial_out = '0;
			d.sdo_oe = '1;
		end else if (cs_rise) begin
			d.active = '0;
			d.sdo_oe = '0;
			d.done = q.active;
			d.len_ok = (q.falls == 5'(FRAME_BITS));
		end else if (q.active && fall_e) begin
			d.rx = {q.rx[14:0], q.serial_in[1]};
			d.falls = (q.falls == 5'h1f) ? q.falls : q.falls + 5'h01;
			d.hdr_stb = (d.falls == 5'(HDR_BITS));
		end else if (q.active && rise_e) begin
			d.rises = (q.rises == 5'h1f) ? q.rises : q.rises + 5'h01;
			if (d.rises > 5'(HDR_BITS) && d.rises <= 5'(FRAME_BITS)) begin
				d.serial_out = fr.rd_word[4'(5'(FRAME_BITS) - d.rises)];
			end else begin
				d.serial_out = '0;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
			q.cs <= 3'h7;
		end else begin
			q <= d;
		end
	end

	assign serial_out        = q.serial_out;
	assign sdo_oe     = q.sdo_oe;
	assign fr.hdr     = q.rx[3:0];
	assign fr.hdr_stb = q.hdr_stb;
	assign fr.done    = q.done;
	assign fr.len_ok  = q.len_ok;
	assign fr.rx_word = q.rx;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_sdo_float;
		q.cs[1] |=> !sdo_oe;
	endproperty
	a_sdo_float: assert property (p_sdo_float) else $error("serial out driven while deselected");

	property p_sample_fall;
		q.active && fall_e && !cs_rise |=> fr.rx_word[0] == $past(q.serial_in[1]);
	endproperty
	a_sample_fall: assert property (p_sample_fall) else $error("bit not sampled on falling edge");

	property p_bad_len;
		cs_rise && q.active && q.falls != 5'h10 |=> fr.done && !fr.len_ok;
	endproperty
	a_bad_len: assert property (p_bad_len) else $error("wrong clock count not flagged");
endmodule

// ---- verilog/sbc_spi_port.sv ----
// How it works
// - Interrupt pin low while any flag set and no release window runs
// - Reading interrupt flags clears those latched at header time
// - Flags held clear during system reset
// - Pin released high after read, minimum time
// - Unread interrupt past timeout forces system reset
// - Limited sources once per watchdog period, Normal
// - Select active low, data out floats otherwise
// - Sample falling edge, shift rising edge
// - Only sixteen clocks accepted; else failure flag
// - Wrong count in start-up/restart resets system
// - Forbidden mode change resets system immediately
// - Undefined mode or period code resets, ignored
// - Full duplex: feedback shifts out meanwhile
// - Four header bits then twelve data bits
// - Header: address, feedback select, read-only
// - Read-only frame changes no register, but a flag read still clears the flags
// - Address 00: mode control, status/diagnosis
// - Address 01: enables or special mode
// - Address 10: configuration or general purpose 0
// - Address 11: phy control or general purpose 1
// - Mode write serves watchdog and selects mode
// - Bit 12 set suppresses mode control write
// - Flash entry sequence resets and arms flash
module sbc_spi_port
	import sbc_pkg::*;
#(
	parameter int          IRQ_TIMEOUT_CYC = IRQ_READOUT_CYCLES,
	parameter logic [11:0] LIMITED_MASK    = LIMITED_SRC_MASK
) (
	input  wire logic        REF_CLK,
	input  wire logic        RESET_N,
	input  wire logic        SERIAL_CLK,
	input  wire logic        CHIP_SELECT_N,
	input  wire logic        SERIAL_IN,
	output logic             SERIAL_OUT,
	output logic             SERIAL_OUT_OE,
	output logic             IRQ_OUT_N,
	output logic             IRQ_OUT_N_OE,
	output logic             SYSTEM_RESET_OUT_N,
	output logic [3:0]       RESET_SOURCE_CODE,
	input  wire logic [2:0]  OP_MODE,
	input  wire logic [11:0] STATUS_IN,
	input  wire logic [11:0] DIAGNOSIS_IN,
	input  wire logic [11:0] IRQ_EVENTS,
	input  wire logic        WD_PERIOD_TICK,
	output logic             MODE_WRITE,
	output logic [11:0]      MODE_CONTROL,
	output logic [11:0]      IRQ_ENABLE,
	output logic [11:0]      SPECIAL_MODE,
	output logic [11:0]      SYSTEM_CONFIG,
	output logic [11:0]      GENERAL_PURPOSE_0,
	output logic [11:0]      GENERAL_PURPOSE_1,
	output logic [11:0]      PHY_CONTROL
);
	localparam int TO_W  = $clog2(IRQ_TIMEOUT_CYC + 1);
	localparam int REL_W = $clog2(IRQ_RELEASE_CYCLES + 1);
	localparam int RST_W = $clog2(RESET_PULSE_CYCLES + 1);

	typedef struct packed {
		logic [11:0]      flags;
		logic [11:0]      irq_en;
		logic [11:0]      special;
		logic [11:0]      cfg;
		logic [11:0]      gp0;
		logic [11:0]      gp1;
		logic [11:0]      phy;
		logic [11:0]      mode_data;
		logic             mode_wr;
		logic [11:0]      rdata;
		logic [11:0]      fired;
		logic [REL_W-1:0] rel_cnt;
		logic [TO_W-1:0]  to_cnt;
		logic [RST_W-1:0] rst_cnt;
		logic             rst_n;
		logic [3:0]       rst_src;
		logic [1:0]       seq;
		logic             armed;
		logic             irq_n;
		logic             irq_oe;
	} sbc_port_t;

	sbc_port_t   q;
	sbc_port_t   d;
	sbc_frame_if fr ();

	logic [1:0]  f_addr;
	logic        f_fsel;
	logic        f_ro;
	logic [2:0]  f_om;
	logic [5:0]  f_nwp;
	logic        irq_mode;
	logic        hw_mode;
	logic        boot_mode;
	logic        good_frame;
	logic        flag_read;
	logic        code_bad;
	logic        move_bad;
	logic [11:0] ev;
	logic [11:0] clr;
	logic        rst_req;
	logic [3:0]  rst_src;

	// Serial shift engine with pin synchronisers
	sbc_spi_shifter u_shift (
		.clk      (REF_CLK),
		.rst_n    (RESET_N),
		.sck_pin  (SERIAL_CLK),
		.cs_n_pin (CHIP_SELECT_N),
		.sdi_pin  (SERIAL_IN),
		.serial_out      (SERIAL_OUT),
		.sdo_oe   (SERIAL_OUT_OE),
		.fr       (fr.shifter)
	);

	// Header and data fields of the finished frame
	assign f_addr     = fr.rx_word[POS_ADDR +: 2];
	assign f_fsel     = fr.rx_word[POS_FSEL];
	assign f_ro       = fr.rx_word[POS_RO];
	assign f_om       = fr.rx_word[POS_OM +: 3];
	assign f_nwp      = fr.rx_word[POS_NWP +: 6];
	assign irq_mode   = (OP_MODE == MODE_NORMAL) || (OP_MODE == MODE_STANDBY)
			|| (OP_MODE == MODE_FLASH);
	assign hw_mode    = (OP_MODE == MODE_NORMAL) || (OP_MODE == MODE_STANDBY);
	assign boot_mode  = (OP_MODE == MODE_STARTUP) || (OP_MODE == MODE_RESTART);
	assign good_frame = fr.done && fr.len_ok && q.rst_n;
	assign flag_read  = good_frame && f_addr == ADDR_IRQ && f_fsel && irq_mode;
	assign code_bad   = !nwp_legal(f_nwp) || f_om == 3'h0;
	assign move_bad   = !mode_allowed(OP_MODE, f_om, q.armed);

	// Feedback word chosen once the header is in
	assign fr.rd_word = q.rdata;

	// Next state of registers, interrupt and reset control
	always_comb begin
		d = q;
		d.mode_wr = '0;
		clr = '0;
		rst_req = '0;
		rst_src = RSRC_NONE;
		ev = IRQ_EVENTS & q.irq_en;
		if (OP_MODE == MODE_NORMAL) begin
			ev = ev & ~(LIMITED_MASK & q.fired);
		end
		d.fired = (WD_PERIOD_TICK ? 12'h000 : q.fired) | (ev & LIMITED_MASK);
		// Feedback select at header time
		if (fr.hdr_stb) begin
			if (fr.hdr[3:2] == ADDR_MODE) begin
				d.rdata = fr.hdr[1] ? DIAGNOSIS_IN : STATUS_IN;
			end else if (fr.hdr[3:2] == ADDR_IRQ) begin
				if (!fr.hdr[1]) begin
					d.rdata = q.irq_en;
				end else if (irq_mode) begin
					d.rdata = q.flags;
				end else begin
					d.rdata = q.special;
				end
			end else if (fr.hdr[3:2] == ADDR_CFG) begin
				d.rdata = fr.hdr[1] ? q.gp0 : q.cfg;
			end else begin
				d.rdata = fr.hdr[1] ? q.gp1 : q.phy;
			end
		end
		// Frame end: length check, writes and mode checks
		if (fr.done && q.rst_n) begin
			if (!fr.len_ok) begin
				if (boot_mode) begin
					rst_req = '1;
					rst_src = RSRC_SPI_CLOCK;
				end else if (q.irq_en[IRQ_SPI_BIT]) begin
					ev[IRQ_SPI_BIT] = '1;
				end
			end else if (!f_ro) begin
				case (f_addr)
					ADDR_MODE: begin
						if (code_bad) begin
							rst_req = '1;
							rst_src = RSRC_BAD_CODE;
						end else if (move_bad) begin
							rst_req = '1;
							rst_src = RSRC_BAD_MODE;
						end else begin
							d.mode_data = fr.rx_word[11:0];
							d.mode_wr = '1;
							d.armed = '0;
							if (OP_MODE != MODE_NORMAL) begin
								d.seq = 2'h0;
							end else if (f_om == (q.seq[0] ? OM_FLASH : OM_NORMAL)) begin
								d.seq = q.seq + 2'h1;
								if (q.seq == 2'h3) begin
									rst_req = '1;
									rst_src = RSRC_FLASH_ENTRY;
									d.armed = '1;
								end
							end else begin
								d.seq = (f_om == OM_NORMAL) ? 2'h1 : 2'h0;
							end
						end
					end
					ADDR_IRQ: begin
						if (irq_mode) begin
							d.irq_en = fr.rx_word[11:0];
						end else begin
							d.special = fr.rx_word[11:0];
						end
					end
					ADDR_CFG: begin
						if (hw_mode) begin
							d.cfg = fr.rx_word[11:0];
						end else begin
							d.gp0 = fr.rx_word[11:0];
						end
					end
					default: begin
						if (hw_mode) begin
							d.phy = fr.rx_word[11:0];
						end else begin
							d.gp1 = fr.rx_word[11:0];
						end
					end
				endcase
			end
			if (flag_read) begin
				clr = q.rdata;
			end
		end
		// New events win over the read clear
		d.flags = (q.flags & ~clr) | ev;
		// Release window after a read
		if (flag_read) begin
			d.rel_cnt = REL_W'(IRQ_RELEASE_CYCLES);
		end else if (q.rel_cnt != '0) begin
			d.rel_cnt = q.rel_cnt - REL_W'(1);
		end
		// Read-out supervision
		if (q.flags == '0 || flag_read) begin
			d.to_cnt = '0;
		end else if (q.to_cnt == TO_W'(IRQ_TIMEOUT_CYC - 1)) begin
			d.to_cnt = '0;
			rst_req = '1;
			rst_src = RSRC_IRQ_TIMEOUT;
		end else begin
			d.to_cnt = q.to_cnt + TO_W'(1);
		end
		// System reset pulse
		if (rst_req) begin
			d.rst_cnt = RST_W'(RESET_PULSE_CYCLES);
			d.rst_src = rst_src;
		end else if (q.rst_cnt != '0) begin
			d.rst_cnt = q.rst_cnt - RST_W'(1);
		end
		d.rst_n = (d.rst_cnt == '0);
		if (!q.rst_n) begin
			d.flags = '0;
			d.to_cnt = '0;
		end
		// Open-drain interrupt pin
		d.irq_oe = (d.flags != '0) && (d.rel_cnt == '0);
		d.irq_n = !d.irq_oe;
	end

	// State register
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			q <= '0;
			q.rst_n <= '1;
			q.irq_n <= '1;
			q.irq_en <= REG_RESET;
		end else begin
			q <= d;
		end
	end

	assign IRQ_OUT_N          = q.irq_n;
	assign IRQ_OUT_N_OE       = q.irq_oe;
	assign SYSTEM_RESET_OUT_N = q.rst_n;
	assign RESET_SOURCE_CODE  = q.rst_src;
	assign MODE_WRITE         = q.mode_wr;
	assign MODE_CONTROL       = q.mode_data;
	assign IRQ_ENABLE         = q.irq_en;
	assign SPECIAL_MODE       = q.special;
	assign SYSTEM_CONFIG      = q.cfg;
	assign GENERAL_PURPOSE_0  = q.gp0;
	assign GENERAL_PURPOSE_1  = q.gp1;
	assign PHY_CONTROL        = q.phy;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	// Pin follows the flags once no release window runs
	property p_irq_low;
		q.rel_cnt == '0 && IRQ_EVENTS == '0 && q.rst_n && !fr.done |=>
			(IRQ_OUT_N_OE && !IRQ_OUT_N) == ($past(q.flags) != '0);
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("interrupt pin disagrees with flags");

	property p_read_clear;
		flag_read && IRQ_EVENTS == '0 |=> (q.flags & $past(q.rdata)) == '0;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");

	property p_reset_clear;
		!SYSTEM_RESET_OUT_N |=> q.flags == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("flags kept during reset");

	property p_release;
		flag_read |=> !IRQ_OUT_N_OE [*8];
	endproperty
	a_release: assert property (p_release) else $error("pin not released after read");

	property p_timeout;
		q.to_cnt == TO_W'(IRQ_TIMEOUT_CYC - 1) && q.flags != '0 && !flag_read && q.rst_n
			|=> !SYSTEM_RESET_OUT_N && RESET_SOURCE_CODE == RSRC_IRQ_TIMEOUT;
	endproperty
	a_timeout: assert property (p_timeout) else $error("no reset after read-out timeout");

	property p_limited;
		OP_MODE == MODE_NORMAL |-> (ev & q.fired & LIMITED_MASK) == '0;
	endproperty
	a_limited: assert property (p_limited) else $error("limited source raised twice");

	property p_spi_flag;
		fr.done && !fr.len_ok && irq_mode && q.irq_en[IRQ_SPI_BIT] && q.rst_n
			|=> q.flags[IRQ_SPI_BIT] && !MODE_WRITE;
	endproperty
	a_spi_flag: assert property (p_spi_flag) else $error("clock count failure not flagged");

	property p_boot_len;
		fr.done && !fr.len_ok && boot_mode && q.rst_n |=> !SYSTEM_RESET_OUT_N ##1 !SYSTEM_RESET_OUT_N;
	endproperty
	a_boot_len: assert property (p_boot_len) else $error("no reset on bad count at boot");

	property p_bad_move;
		good_frame && !f_ro && f_addr == ADDR_MODE && !code_bad && move_bad
			|=> !SYSTEM_RESET_OUT_N && $stable(MODE_CONTROL);
	endproperty
	a_bad_move: assert property (p_bad_move) else $error("forbidden mode change accepted");

	property p_bad_code;
		good_frame && !f_ro && f_addr == ADDR_MODE && code_bad
			|=> !SYSTEM_RESET_OUT_N && !MODE_WRITE && $stable(MODE_CONTROL);
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("illegal mode code accepted");

	property p_read_only;
		good_frame && f_ro |=> !MODE_WRITE && $stable(IRQ_ENABLE) && $stable(SYSTEM_CONFIG)
			&& $stable(PHY_CONTROL) && $stable(GENERAL_PURPOSE_0);
	endproperty
	a_read_only: assert property (p_read_only) else $error("read-only frame changed state");

	property p_mode_write;
		good_frame && !f_ro && f_addr == ADDR_MODE && !code_bad && !move_bad
			|=> MODE_WRITE && MODE_CONTROL == $past(fr.rx_word[11:0]) ##1 !MODE_WRITE;
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode write not strobed once");

	c_flash_entry: cover property (!SYSTEM_RESET_OUT_N && RESET_SOURCE_CODE == RSRC_FLASH_ENTRY);
	c_flag_read: cover property (flag_read && q.flags != '0);
	c_timeout: cover property (RESET_SOURCE_CODE == RSRC_IRQ_TIMEOUT);
	c_bad_len: cover property (fr.done && !fr.len_ok);
endmodule

// ---- tb/sbc_spi_master.sv ----
module sbc_spi_master (
	input  wire logic clk,
	output logic      sck,
	output logic      cs_n,
	output logic      serial_in,
	input  wire logic serial_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Link idles with select high and clock low
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		serial_in = 1'b0;
	end

	// One frame of n clock periods, most significant bit first, full duplex
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge clk);
		#3;
		cs_n = 1'b0;
		serial_in = tx[15];
		for (int i = 0; i < n; i++) begin
			#200;
			sck = 1'b1;
			if (i > 0 && i < 16) begin
				serial_in = tx[15-i];
			end else if (i > 0) begin
				serial_in = ~serial_in;
			end
			#200;
			sck = 1'b0;
			rx = {rx[14:0], serial_out};
		end
		#200;
		cs_n = 1'b1;
		serial_in = ~serial_in; // Released line must not keep the last bit
		#200;
	endtask
endmodule

// ---- tb/sbc_spi_port_tb.sv ----
module sbc_spi_port_tb
	import sbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  op_mode = MODE_NORMAL;
	logic [11:0] status_in = 12'ha5c;
	logic [11:0] diag_in = 12'h3c9;
	logic [11:0] irq_ev = 12'h000;
	logic        wd_tick = 1'b0;
	logic        serial_out, sdo_oe, irq_n, irq_oe, sys_rst_n, mode_wr, sck, cs_n, serial_in;
	logic [3:0]  rsrc;
	logic [11:0] mode_ctl, irq_en, spec, cfg, gp0, gp1, phy;
	logic [15:0] rx;
	int          n_errors = 0;
	int          checks_done = 0;
	int          n_mode_wr = 0;
	// Pin levels: data out floats, interrupt line has a pull-up
	wire         sdo_line = sdo_oe ? serial_out : 1'bz;
	wire         irq_line = irq_oe ? irq_n : 1'b1;

	// Clock and mode-write pulse counter
	always #25 clk = ~clk;
	always @(posedge clk) if (mode_wr === 1'b1) n_mode_wr++;

	sbc_spi_port #(.IRQ_TIMEOUT_CYC(200)) i_dut (
		.REF_CLK           (clk),
		.RESET_N           (rst_n),
		.SERIAL_CLK        (sck),
		.CHIP_SELECT_N     (cs_n),
		.SERIAL_IN         (serial_in),
		.SERIAL_OUT        (serial_out),
		.SERIAL_OUT_OE     (sdo_oe),
		.IRQ_OUT_N         (irq_n),
		.IRQ_OUT_N_OE      (irq_oe),
		.SYSTEM_RESET_OUT_N(sys_rst_n),
		.RESET_SOURCE_CODE (rsrc),
		.OP_MODE           (op_mode),
		.STATUS_IN         (status_in),
		.DIAGNOSIS_IN      (diag_in),
		.IRQ_EVENTS        (irq_ev),
		.WD_PERIOD_TICK    (wd_tick),
		.MODE_WRITE        (mode_wr),
		.MODE_CONTROL      (mode_ctl),
		.IRQ_ENABLE        (irq_en),
		.SPECIAL_MODE      (spec),
		.SYSTEM_CONFIG     (cfg),
		.GENERAL_PURPOSE_0 (gp0),
		.GENERAL_PURPOSE_1 (gp1),
		.PHY_CONTROL       (phy)
	);

	sbc_spi_master i_master (
		.clk (clk),
		.sck (sck),
		.cs_n(cs_n),
		.serial_in (serial_in),
		.serial_out (sdo_line)
	);

	task automatic tally_and_finish();
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Inputs change a little after the rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#3;
	endtask

	// Bounded wait on the system reset or the interrupt line
	task automatic await(input bit on_rst, input logic v, input int lim);
		int k;
		k = 0;
		while (((on_rst ? sys_rst_n : irq_line) !== v) && k < lim) begin
			cyc(1);
			k++;
		end
		if (k >= lim) begin
			n_errors++;
			$display("mismatch wait_%0d expected %b seen timeout", on_rst, v);
			tally_and_finish();
		end
	endtask

	function automatic logic [15:0] frm(logic [1:0] a, logic fs, logic ro, logic [11:0] d);
		return {a, fs, ro, d};
	endfunction

	function automatic logic [11:0] port_of(int st, int a);
		case (a)
			1: return st ? spec : irq_en;
			2: return st ? gp0 : cfg;
			default: return st ? gp1 : phy;
		endcase
	endfunction

	task automatic go(input logic [15:0] tx);
		i_master.xfer(tx, 16, rx);
		cyc(8);
	endtask

	task automatic pulse(input logic [11:0] ev, input logic tick);
		irq_ev = ev;
		wd_tick = tick;
		cyc(1);
		irq_ev = 12'h000;
		wd_tick = 1'b0;
	endtask

	// Read-only frames return status or diagnosis and write nothing
	task automatic t_readback();
		go(frm(ADDR_MODE, 1'b0, 1'b1, 12'h248));
		cmp("status", {4'h0, status_in}, rx);
		go(frm(ADDR_MODE, 1'b1, 1'b1, 12'h248));
		cmp("diagnosis", {4'h0, diag_in}, rx);
		cmp("mode_pulses", 16'h0000, 16'(n_mode_wr));
		cmp("sdo_float", {15'h0000, 1'bz}, {15'h0000, sdo_line});
	endtask

	// A mode write serves the watchdog and is taken whole
	task automatic t_mode_write();
		go(frm(ADDR_MODE, 1'b0, 1'b0, 12'h248));
		cmp("mode_pulses", 16'h0001, 16'(n_mode_wr));
		cmp("mode_ctl", 16'h0248, {4'h0, mode_ctl});
	endtask

	// Writes land where address and mode select; the other register keeps
	task automatic t_regs();
		logic [11:0] d;
		for (int st = 0; st < 2; st++) begin
			op_mode = st ? MODE_STARTUP : MODE_NORMAL;
			for (int a = 1; a < 4; a++) begin
				d = 12'(a) * 12'h111 + (st ? 12'h808 : 12'h000);
				go(frm(2'(a), 1'b0, 1'b0, d));
				cmp("reg_port", {4'h0, d}, {4'h0, port_of(st, a)});
				cmp("reg_other", {4'h0, st ? 12'(a) * 12'h111 : 12'h000},
					{4'h0, port_of(1 - st, a)});
				go(frm(2'(a), 1'(st), 1'b1, 12'h000));
				cmp("reg_readback", {4'h0, d}, rx);
			end
		end
		op_mode = MODE_NORMAL;
	endtask

	// Wrong clock count: ignored, flagged, read out, then left to time out
	task automatic t_badcount();
		i_master.xfer(frm(ADDR_CFG, 1'b0, 1'b0, 12'hfff), 15, rx);
		await(1'b0, 1'b0, 20);
		cmp("cfg_kept", 16'h0222, {4'h0, cfg});
		go(frm(ADDR_IRQ, 1'b1, 1'b1, 12'h000));
		cmp("flags", 16'h0001, rx);
		cmp("irq_released", 16'h0001, {15'h0000, irq_line});
		pulse(12'h001, 1'b0);
		cyc(25);
		cmp("irq_held_high", 16'h0001, {15'h0000, irq_line});
		await(1'b0, 1'b0, 20);
		await(1'b1, 1'b0, 260);
		cmp("reset_cause", {12'h000, RSRC_IRQ_TIMEOUT}, {12'h000, rsrc});
		cyc(3);
		cmp("irq_in_reset", 16'h0001, {15'h0000, irq_line});
		await(1'b1, 1'b1, 40);
		op_mode = MODE_STARTUP;
		i_master.xfer(frm(ADDR_CFG, 1'b0, 1'b1, 12'h000), 17, rx);
		await(1'b1, 1'b0, 20);
		cmp("reset_cause", {12'h000, RSRC_SPI_CLOCK}, {12'h000, rsrc});
		cyc(3);
		cmp("irq_no_flag", 16'h0001, {15'h0000, irq_line});
		await(1'b1, 1'b1, 40);
		op_mode = MODE_NORMAL;
	endtask

	// Undefined codes and a forbidden move reset the system
	task automatic t_mode_errors();
		logic [2:0]  cur [3] = '{MODE_NORMAL, MODE_NORMAL, MODE_STANDBY};
		logic [11:0] dat [3] = '{12'h008, 12'h240, {6'h09, OM_FLASH, 3'h0}};
		logic [3:0]  src [3] = '{RSRC_BAD_CODE, RSRC_BAD_CODE, RSRC_BAD_MODE};
		for (int i = 0; i < 3; i++) begin
			op_mode = cur[i];
			go(frm(ADDR_MODE, 1'b0, 1'b0, dat[i]));
			await(1'b1, 1'b0, 20);
			cmp("reset_cause", {12'h000, src[i]}, {12'h000, rsrc});
			cmp("mode_kept", 16'h0248, {4'h0, mode_ctl});
			await(1'b1, 1'b1, 40);
		end
		op_mode = MODE_NORMAL;
	endtask

	// Normal, Flash, Normal, Flash entry resets and arms the init-flash move
	task automatic t_flash();
		logic [2:0] seq [4] = '{OM_NORMAL, OM_FLASH, OM_NORMAL, OM_FLASH};
		for (int i = 0; i < 4; i++) begin
			go(frm(ADDR_MODE, 1'b0, 1'b0, {6'h09, seq[i], 3'h0}));
		end
		await(1'b1, 1'b0, 20);
		cmp("reset_cause", {12'h000, RSRC_FLASH_ENTRY}, {12'h000, rsrc});
		await(1'b1, 1'b1, 40);
		op_mode = MODE_STARTUP;
		go(frm(ADDR_MODE, 1'b0, 1'b0, {6'h09, OM_INIT_FLASH, 3'h0}));
		cmp("sys_rst_n", 16'h0001, {15'h0000, sys_rst_n});
		cmp("mode_ctl", 16'h0258, {4'h0, mode_ctl});
		op_mode = MODE_NORMAL;
	endtask

	// A limited source fires once per watchdog period in Normal mode
	task automatic t_limit();
		go(frm(ADDR_IRQ, 1'b0, 1'b0, 12'h010));
		for (int k = 0; k < 3; k++) begin
			pulse(12'h000, k == 2);
			pulse(12'h010, 1'b0);
			cyc(4);
			go(frm(ADDR_IRQ, 1'b1, 1'b1, 12'h000));
			cmp("limited_flag", k == 1 ? 16'h0000 : 16'h0010, rx);
		end
	endtask

	// Main sequence
	initial begin
		cyc(8);
		rst_n = 1'b1;
		cyc(4);
		cmp("reset_state", 16'h0020, {8'h00, sdo_oe, irq_oe, sys_rst_n, mode_wr, rsrc});
		t_readback();
		t_mode_write();
		t_regs();
		t_badcount();
		t_mode_errors();
		t_flash();
		t_limit();
		tally_and_finish();
	end
endmodule
